// File: hdl/rss_sequencer.sv
// Purpose: Strobe sequencer for four switching rails with register access
// Assumes: Synchronous register port, one access per cycle
// Notes: Counts at 125 MHz; gap lengths are parameters for simulation
`timescale 1ns/1ps
module rss_sequencer
   import rss_pkg::*;
#(
   parameter int P_SHORT_CYC = RSS_SHORT_CYC,
   parameter int P_LONG_CYC = RSS_LONG_CYC
)
(
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_ce,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic [7:0] i_gap_select,
   input wire logic i_power_up,
   input wire logic i_power_down,
   output logic [7:0] o_rdata,
   output logic o_busy,
   output logic o_up_dir,
   output logic [3:0] o_strobe,
   output logic o_strobe_pulse,
   output logic [3:0] o_rail_en
);
   typedef enum {ST_IDLE, ST_STROBE, ST_GAP} rss_state_type;
   typedef struct packed {
      logic [7:0] gap_r;
      logic [7:0] pair_a_r;
      logic [7:0] pair_b_r;
      logic [7:0] rdata_r;
      rss_state_type state_r;
      logic up_r;
      logic [3:0] strobe_r;
      logic [RSS_CNT_W-1:0] cnt_r;
      logic pulse_r;
      logic [3:0] rail_r;
      logic busy_r;
   } rss_regs_type;

   rss_regs_type cur_r;
   rss_regs_type cur_nxt;
   logic [3:0] hit;
   logic [3:0] owned;
   logic [15:0] slots;
   logic gap_long;
   logic [RSS_CNT_W-1:0] gap_len;

   assign slots = {cur_r.pair_b_r, cur_r.pair_a_r};

   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : g_rail
         rss_slot_decode u_dec (
            .i_slot(slots[4*g +: 4]),
            .i_strobe(cur_r.strobe_r),
            .o_hit(hit[g]),
            .o_owned(owned[g])
         );
      end
   endgenerate

   // Gap index: after strobe n on power-up, before strobe n on power-down
   always_comb
   begin
      logic [3:0] gi;
      logic [3:0] gidx;
      logic [RSS_CNT_W-1:0] base;
      gi = cur_r.up_r ? cur_r.strobe_r : cur_r.strobe_r - 4'h1;
      gidx = gi - 4'h1;
      base = '0;
      if (gi == 4'h9)
         gap_long = cur_r.gap_r[RSS_GAP_NINE_BIT];
      else if (gi >= 4'h1 && gi <= 4'h8)
         gap_long = i_gap_select[gidx[2:0]];
      else
         gap_long = 1'b0;
      base = gap_long ? RSS_CNT_W'(P_LONG_CYC) : RSS_CNT_W'(P_SHORT_CYC);
      if (!cur_r.up_r && cur_r.gap_r[RSS_SCALE_BIT])
         gap_len = RSS_CNT_W'(base * RSS_SCALE_FACTOR);
      else
         gap_len = base;
   end

   always_comb
   begin
      cur_nxt = cur_r;
      cur_nxt.pulse_r = 1'b0;
      if (i_wr)
      begin
         case (i_addr)
            RSS_OFS_GAP: cur_nxt.gap_r = i_wdata & RSS_GAP_RW_MASK;
            RSS_OFS_PAIR_A: cur_nxt.pair_a_r = i_wdata;
            RSS_OFS_PAIR_B: cur_nxt.pair_b_r = i_wdata;
            default: ;
         endcase
      end
      if (i_rd)
      begin
         case (i_addr)
            RSS_OFS_GAP: cur_nxt.rdata_r = cur_r.gap_r;
            RSS_OFS_PAIR_A: cur_nxt.rdata_r = cur_r.pair_a_r;
            RSS_OFS_PAIR_B: cur_nxt.rdata_r = cur_r.pair_b_r;
            default: cur_nxt.rdata_r = 8'h00;
         endcase
      end
      case (cur_r.state_r)
         ST_IDLE:
         begin
            if (i_power_up)
            begin
               cur_nxt.up_r = 1'b1;
               cur_nxt.strobe_r = RSS_STROBE_FIRST;
               cur_nxt.state_r = ST_STROBE;
            end
            else if (i_power_down)
            begin
               cur_nxt.up_r = 1'b0;
               cur_nxt.strobe_r = RSS_STROBE_LAST;
               cur_nxt.state_r = ST_STROBE;
            end
         end
         ST_STROBE:
         begin
            cur_nxt.pulse_r = 1'b1;
            // Rails outside control keep their state
            for (int i = 0; i < 4; i++)
               if (hit[i])
                  cur_nxt.rail_r[i] = cur_r.up_r;
            cur_nxt.cnt_r = gap_len;
            if ((cur_r.up_r && cur_r.strobe_r == RSS_STROBE_LAST) ||
                (!cur_r.up_r && cur_r.strobe_r == RSS_STROBE_FIRST))
               cur_nxt.state_r = ST_IDLE;
            else
               cur_nxt.state_r = ST_GAP;
         end
         ST_GAP:
         begin
            if (cur_r.cnt_r <= RSS_CNT_W'(2))
            begin
               cur_nxt.strobe_r = cur_r.up_r ? cur_r.strobe_r + 4'h1 :
                                  cur_r.strobe_r - 4'h1;
               cur_nxt.state_r = ST_STROBE;
            end
            else
               cur_nxt.cnt_r = cur_r.cnt_r - RSS_CNT_W'(1);
         end
         default: cur_nxt.state_r = ST_IDLE;
      endcase
      // Registered so busy leaves the block straight from a flip-flop
      cur_nxt.busy_r = (cur_nxt.state_r != ST_IDLE);
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rstn)
      begin
         cur_r <= '0;
         cur_r.state_r <= ST_IDLE;
         cur_r.gap_r <= RSS_RST_GAP;
         cur_r.pair_a_r <= RSS_RST_PAIR_A;
         cur_r.pair_b_r <= RSS_RST_PAIR_B;
      end
      else if (i_ce)
         cur_r <= cur_nxt;
   end

   assign o_rdata = cur_r.rdata_r;
   assign o_busy = cur_r.busy_r;
   assign o_up_dir = cur_r.up_r;
   assign o_strobe = cur_r.strobe_r;
   assign o_strobe_pulse = cur_r.pulse_r;
   assign o_rail_en = cur_r.rail_r;

   // Assertions
   AST_SCALED_GAP: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_ce && cur_r.state_r == ST_STROBE && !cur_r.up_r && cur_r.gap_r[RSS_SCALE_BIT]
       && cur_r.strobe_r != RSS_STROBE_FIRST) |=>
      (cur_r.cnt_r == RSS_CNT_W'(P_SHORT_CYC * RSS_SCALE_FACTOR)
       || cur_r.cnt_r == RSS_CNT_W'(P_LONG_CYC * RSS_SCALE_FACTOR)))
      else $error("power-down gap not scaled");
   AST_UP_UNSCALED: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_ce && cur_r.up_r && cur_r.state_r == ST_STROBE) |=>
      (cur_r.cnt_r == RSS_CNT_W'(P_SHORT_CYC) || cur_r.cnt_r == RSS_CNT_W'(P_LONG_CYC)))
      else $error("power-up gap scaled");
   AST_GAP_NINE: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_ce && cur_r.up_r && cur_r.strobe_r == 4'h9 && cur_r.state_r == ST_STROBE) |=>
      cur_r.cnt_r == ($past(cur_r.gap_r[RSS_GAP_NINE_BIT]) ? RSS_CNT_W'(P_LONG_CYC)
                      : RSS_CNT_W'(P_SHORT_CYC)))
      else $error("gap nine length wrong");
   AST_RAIL_ON: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_ce && cur_r.state_r == ST_STROBE && cur_r.up_r && hit[0]) |=> o_rail_en[0])
      else $error("rail not enabled at its strobe");
   AST_RAIL_OFF: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_ce && cur_r.state_r == ST_STROBE && !cur_r.up_r && hit[0]) |=> !o_rail_en[0])
      else $error("rail not disabled at its strobe");
   AST_UNOWNED_HOLD: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_ce && !owned[1] && !i_wr) |=> $stable(o_rail_en[1]))
      else $error("uncontrolled rail changed");
   AST_PAIR_A_READ: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_ce && i_rd && !i_wr && i_addr == RSS_OFS_PAIR_A) |=> o_rdata == $past(cur_r.pair_a_r))
      else $error("pair a read wrong");
   AST_PAIR_B_WRITE: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_ce && i_wr && i_addr == RSS_OFS_PAIR_B) |=> cur_r.pair_b_r == $past(i_wdata))
      else $error("pair b write lost");
   AST_ORDER: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_ce && cur_r.state_r == ST_GAP && cur_r.cnt_r <= RSS_CNT_W'(2) && cur_r.up_r)
      |=> o_strobe == $past(o_strobe) + 4'h1)
      else $error("strobe order broken");
   AST_PULSE_ONE: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_ce && o_strobe_pulse) |=> !o_strobe_pulse)
      else $error("strobe pulse longer than one cycle");
   AST_START_UP: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_ce && !o_busy && i_power_up) |=> (o_busy && o_up_dir && o_strobe == RSS_STROBE_FIRST))
      else $error("power-up did not start at the first strobe");
   COV_UP: cover property (@(posedge i_clk) o_strobe_pulse && o_up_dir && o_strobe == 4'ha);
   COV_DOWN: cover property (@(posedge i_clk) o_strobe_pulse && !o_up_dir && o_strobe == 4'h1);
   COV_SCALED: cover property (@(posedge i_clk) !o_up_dir && cur_r.gap_r[RSS_SCALE_BIT] && o_busy);
   COV_REFUSED: cover property (@(posedge i_clk) o_busy && (i_power_up || i_power_down));
endmodule

// File: inc/rss_pkg.sv
// Purpose: Constants for the rail strobe sequencer
// Assumes: 125 MHz clock
// Notes: Offsets are register subaddresses
package rss_pkg;
   localparam logic [7:0] RSS_OFS_GAP = 8'h21;
   localparam logic [7:0] RSS_OFS_PAIR_A = 8'h22;
   localparam logic [7:0] RSS_OFS_PAIR_B = 8'h23;
   localparam logic [7:0] RSS_RST_GAP = 8'h00;
   localparam logic [7:0] RSS_RST_PAIR_A = 8'h98;
   localparam logic [7:0] RSS_RST_PAIR_B = 8'h75;
   localparam logic [7:0] RSS_GAP_RW_MASK = 8'h81;
   localparam int RSS_SCALE_BIT = 7;
   localparam int RSS_GAP_NINE_BIT = 0;
   localparam logic [3:0] RSS_SLOT_MIN = 4'h3;
   localparam logic [3:0] RSS_SLOT_MAX = 4'ha;
   localparam logic [3:0] RSS_STROBE_FIRST = 4'h1;
   localparam logic [3:0] RSS_STROBE_LAST = 4'ha;
   localparam int RSS_SCALE_FACTOR = 10;
   localparam int RSS_CLK_MHZ = 125;
   localparam int RSS_SHORT_MS = 2;
   localparam int RSS_LONG_MS = 5;
   localparam int RSS_SHORT_CYC = RSS_SHORT_MS * RSS_CLK_MHZ * 1000;
   localparam int RSS_LONG_CYC = RSS_LONG_MS * RSS_CLK_MHZ * 1000;
   localparam int RSS_CNT_W = 26;
endpackage

// File: hdl/rss_slot_decode.sv
// Purpose: Decode one rail slot field against the current strobe
// Assumes: Strobe numbers 1 to 10
// Notes: Purely combinational
`timescale 1ns/1ps
module rss_slot_decode
   import rss_pkg::*;
(
   input wire logic [3:0] i_slot,
   input wire logic [3:0] i_strobe,
   output logic o_hit,
   output logic o_owned
);
   always_comb
   begin
      o_owned = (i_slot >= RSS_SLOT_MIN) && (i_slot <= RSS_SLOT_MAX);
      o_hit = o_owned && (i_slot == i_strobe);
   end
endmodule

// File: bench/rss_sequencer_tb.sv
// Purpose: Self-checking bench for the rail strobe sequencer
// Assumes: Gap lengths shortened to 20 and 50 cycles
// Notes: Power-down runs use zero gap selects, so gap mapping is uniform
`timescale 1ns/1ps
module rail_strobe_sequencer_tb_top
   import rss_pkg::*;
;
   localparam int SHORT = 20;
   localparam int LONG = 50;
   logic i_clk = 1'b0;
   logic i_rstn = 1'b0;
   logic i_ce = 1'b1;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [7:0] i_addr = 8'h00;
   logic [7:0] i_wdata = 8'h00;
   logic [7:0] i_gap_select = 8'h00;
   logic i_power_up = 1'b0;
   logic i_power_down = 1'b0;
   logic [7:0] o_rdata;
   logic o_busy;
   logic o_up_dir;
   logic [3:0] o_strobe;
   logic o_strobe_pulse;
   logic [3:0] o_rail_en;
   logic [7:0] r21 = 8'h00;
   logic [7:0] pa = 8'h00;
   logic [7:0] pb = 8'h00;
   int n_mismatch = 0;
   int n_tests = 0;
   int cyc = 0;

   rss_sequencer #(.P_SHORT_CYC(SHORT), .P_LONG_CYC(LONG)) uut (.i_clk(i_clk),
      .i_rstn(i_rstn), .i_ce(i_ce), .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_gap_select(i_gap_select), .i_power_up(i_power_up),
      .i_power_down(i_power_down), .o_rdata(o_rdata), .o_busy(o_busy),
      .o_up_dir(o_up_dir), .o_strobe(o_strobe), .o_strobe_pulse(o_strobe_pulse),
      .o_rail_en(o_rail_en));

   initial
   begin
      forever #4 i_clk = ~i_clk;
   end

   task automatic final_report;
      if (n_mismatch == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Hang guard, the longest run is under two thousand cycles
   always @(posedge i_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_mismatch++;
         final_report();
      end
   end

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e)
      begin
         $display("Error %s expected %h seen %h", nm, e, g);
         n_mismatch++;
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_clk);
      i_wr = 1'b1;
      i_addr = a;
      i_wdata = d;
      @(negedge i_clk);
      i_wr = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge i_clk);
      i_rd = 1'b1;
      i_addr = a;
      @(negedge i_clk);
      i_rd = 1'b0;
      chk("rdata", {8'h00, e}, {8'h00, o_rdata});
   endtask

   // Rails owned and on at strobe n: slot up to n on power-up, slot below n on power-down
   function automatic logic [3:0] rails(input int n, input logic up);
      logic [15:0] sl;
      sl = {pb, pa};
      for (int i = 0; i < 4; i++)
         rails[i] = sl[4*i +: 4] >= 4'h3 && sl[4*i +: 4] <= 4'ha
            && (up ? sl[4*i +: 4] <= n : sl[4*i +: 4] < n);
   endfunction

   task automatic run_seq(input logic up);
      int t;
      int n;
      int k;
      int gap;
      @(negedge i_clk);
      i_power_up = up;
      i_power_down = !up;
      for (int s = 1; s <= 10; s++)
      begin
         n = up ? s : 11 - s;
         k = up ? n - 1 : n;
         gap = (s == 1) ? 0 : ((k == 9 ? r21[0] : i_gap_select[k-1]) ? LONG : SHORT);
         gap = (!up && r21[7]) ? gap * 10 : gap;
         if (s == 5)
         begin
            i_power_up = !up;
            i_power_down = up;
         end
         @(negedge i_clk);
         i_power_up = 1'b0;
         i_power_down = 1'b0;
         t = 1;
         while (o_strobe_pulse !== 1'b1 && t < 3000)
         begin
            @(negedge i_clk);
            t++;
         end
         chk("strobe", n[15:0], {12'h000, o_strobe});
         chk("direction", {15'h0000, up}, {15'h0000, o_up_dir});
         chk("busy", {15'h0000, (s < 10)}, {15'h0000, o_busy});
         chk("rails", {12'h000, rails(n, up)}, {12'h000, o_rail_en});
         if (s > 1)
            chk("gap", gap[15:0], t[15:0]);
      end
      repeat (2) @(negedge i_clk);
      chk("busy", 16'h0000, {15'h0000, o_busy});
   endtask

   initial
   begin
      repeat (5) @(negedge i_clk);
      i_rstn = 1'b1;
      rd(RSS_OFS_GAP, RSS_RST_GAP);
      rd(RSS_OFS_PAIR_A, RSS_RST_PAIR_A);
      rd(RSS_OFS_PAIR_B, RSS_RST_PAIR_B);
      rd(8'h30, 8'h00);
      wr(8'h30, 8'h55);
      rd(RSS_OFS_PAIR_A, RSS_RST_PAIR_A);
      r21 = 8'hff;
      wr(RSS_OFS_GAP, r21);
      rd(RSS_OFS_GAP, r21 & RSS_GAP_RW_MASK);
      pa = 8'ha3;
      pb = 8'hb2;
      wr(RSS_OFS_PAIR_A, pa);
      wr(RSS_OFS_PAIR_B, pb);
      rd(RSS_OFS_PAIR_A, pa);
      rd(RSS_OFS_PAIR_B, pb);
      // Enable low freezes everything, so this write must not land
      i_ce = 1'b0;
      wr(RSS_OFS_PAIR_A, 8'h00);
      i_ce = 1'b1;
      rd(RSS_OFS_PAIR_A, pa);
      i_gap_select = 8'h01;
      run_seq(1'b1);
      i_gap_select = 8'h00;
      r21 = 8'h80;
      wr(RSS_OFS_GAP, r21);
      run_seq(1'b0);
      pa = 8'hf4;
      pb = 8'h09;
      r21 = 8'h00;
      wr(RSS_OFS_PAIR_A, pa);
      wr(RSS_OFS_PAIR_B, pb);
      wr(RSS_OFS_GAP, r21);
      i_gap_select = 8'h80;
      run_seq(1'b1);
      i_gap_select = 8'h00;
      run_seq(1'b0);
      final_report();
   end
endmodule
